// file: hdl/selftest_adc_map.svh
// address map, field positions and reset values of the self-test result registers
`ifndef SELFTEST_ADC_MAP_SVH
`define SELFTEST_ADC_MAP_SVH

// register indices; byte address is four times the index
`define ST_CUR_LOW_CH4_IDX 8'h4d
`define ST_CUR_MID_CH4_IDX 8'h4e
`define ST_CUR_HIGH_CH4_IDX 8'h4f
`define ST_CUR_LOW_CH5_IDX 8'h50
`define ST_CUR_MID_CH5_IDX 8'h51
`define ST_CUR_HIGH_CH5_IDX 8'h52
`define ST_CUR_LOW_CH6_IDX 8'h53
`define ST_CUR_MID_CH6_IDX 8'h54
`define ST_CUR_HIGH_CH6_IDX 8'h55
`define ST_CUR_LOW_CH7_IDX 8'h56
`define ST_IRQ_STATUS_IDX 8'h70
`define ST_IRQ_MASK_IDX 8'h71

// slot numbers of the result array
`define SLOT_LOW_CH4 4'h0
`define SLOT_MID_CH4 4'h1
`define SLOT_HIGH_CH4 4'h2
`define SLOT_LOW_CH5 4'h3
`define SLOT_HIGH_CH6 4'h8
`define SLOT_LOW_CH7 4'h9
`define NUM_SLOTS 4'ha

// result word layout
`define VAL_MSB 13
`define VAL_LSB 4
`define UPD_BIT 1
`define PAR_BIT 0
`define WORD_ZERO 16'h0000

// address bits that carry the index
`define IDX_MSB 9
`define IDX_LSB 2

// reset values
`define VALUE_RST 10'h000
`define FLAGS_RST 10'h000

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: hdl/selftest_adc_pkg.sv
// types shared by the self-test result register bank
package selftest_adc_pkg;

    // one conversion result handed over by the self-test sequencer
    typedef struct packed {
        logic valid;
        logic [3:0] slot;
        logic [9:0] value;
    } result_load_type;

    // clearable content of one result register
    typedef struct packed {
        logic [9:0] value;
        logic upd;
    } result_reg_type;

    // read channel phase
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_type;

endpackage

// file: hdl/selftest_adc_result_regs.sv
// self-test current result registers with axi4-lite slave and update interrupt
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "selftest_adc_map.svh"

module selftest_adc_result_regs
    import selftest_adc_pkg::*;
(
    input wire logic aclk, // 40 mhz bus clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire result_load_type load, // new conversion from self-test logic
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [11:0] awaddr, // write byte address
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    output logic [1:0] bresp, // write response code
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    input wire logic [11:0] araddr, // read byte address
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response code
    output logic irq // level interrupt, unmasked update pending
);

    // result word as seen by software: zeros around value, flag and parity
    function automatic logic [15:0] word_of(input result_reg_type r);
        logic [15:0] w;
        w = `WORD_ZERO;
        w[`VAL_MSB:`VAL_LSB] = r.value;
        w[`UPD_BIT] = r.upd;
        w[`PAR_BIT] = ^w[15:1];
        return w;
    endfunction

    // slot of an index, valid only inside the result window
    function automatic logic [3:0] slot_of(input logic [7:0] idx);
        logic [7:0] d;
        d = idx - `ST_CUR_LOW_CH4_IDX;
        return d[3:0];
    endfunction

    function automatic logic is_result(input logic [7:0] idx);
        return (idx >= `ST_CUR_LOW_CH4_IDX) && (idx <= `ST_CUR_LOW_CH7_IDX);
    endfunction

    // state
    result_reg_type [9:0] res;
    result_reg_type [9:0] next_res;
    logic [9:0] status;
    logic [9:0] next_status;
    logic [9:0] mask;
    logic [9:0] next_mask;
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    logic [7:0] wr_idx;
    logic [7:0] next_wr_idx;
    logic [31:0] wr_data;
    logic [31:0] next_wr_data;
    logic [3:0] wr_strb;
    logic [3:0] next_wr_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    rd_state_type rd_state;
    rd_state_type next_rd_state;
    logic next_arready;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_irq;
    logic rd_was_result;
    logic next_rd_was_result;

    // decoded strobes
    logic ar_fire;
    logic [7:0] rd_idx;
    logic [3:0] rd_slot;
    logic rd_hit;
    logic wr_go;
    logic [9:0] bit_en;
    logic load_ok;

    // address decode and handshakes
    always_comb begin
        rd_idx = araddr[`IDX_MSB:`IDX_LSB];
        rd_slot = slot_of(rd_idx);
        rd_hit = is_result(rd_idx);
        ar_fire = arvalid && arready;
        wr_go = aw_held && w_held && !bvalid;
        load_ok = load.valid && (load.slot < `NUM_SLOTS);
        // a status/mask bit takes the write only if its byte lane is strobed
        for (int i = 0; i < 10; i++) begin
            bit_en[i] = wr_strb[i / 8];
        end
    end

    // register bank next state; reads clear, loads set, set wins
    always_comb begin
        next_res = res;
        next_status = status;
        next_mask = mask;
        // the whole register is cleared, payload is never consulted
        if (ar_fire && rd_hit) begin
            next_res[rd_slot] = '0;
        end
        // writes to result registers have no effect at all
        if (wr_go && (wr_idx == `ST_IRQ_STATUS_IDX)) begin
            next_status = status & ~(wr_data[9:0] & bit_en);
        end
        if (wr_go && (wr_idx == `ST_IRQ_MASK_IDX)) begin
            next_mask = (mask & ~bit_en) | (wr_data[9:0] & bit_en);
        end
        // applied last so a load in the clearing cycle survives
        if (load_ok) begin
            next_res[load.slot].value = load.value;
            next_res[load.slot].upd = 1'b1;
            next_status[load.slot] = 1'b1;
        end
        next_irq = |(next_status & next_mask);
    end

    // write channel next state
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_idx = wr_idx;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_wr_idx = awaddr[`IDX_MSB:`IDX_LSB];
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_wr_data = wdata;
            next_wr_strb = wstrb;
        end
        if (wr_go) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            // result registers accept and ignore writes; holes answer slverr
            if (is_result(wr_idx) || (wr_idx == `ST_IRQ_STATUS_IDX) ||
                (wr_idx == `ST_IRQ_MASK_IDX)) begin
                next_bresp = `RESP_OKAY;
            end else begin
                next_bresp = `RESP_SLVERR;
            end
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    // read channel next state; data captured before the clear takes effect
    always_comb begin
        next_rd_state = rd_state;
        next_rdata = rdata;
        next_rresp = rresp;
        next_rd_was_result = rd_was_result;
        case (rd_state)
            RD_IDLE: begin
                if (ar_fire) begin
                    next_rd_state = RD_RESP;
                    next_rresp = `RESP_OKAY;
                    next_rd_was_result = rd_hit;
                    if (rd_hit) begin
                        next_rdata = {16'h0000, word_of(res[rd_slot])};
                    end else if (rd_idx == `ST_IRQ_STATUS_IDX) begin
                        next_rdata = {22'h000000, status};
                    end else if (rd_idx == `ST_IRQ_MASK_IDX) begin
                        next_rdata = {22'h000000, mask};
                    end else begin
                        next_rdata = 32'h00000000;
                        next_rresp = `RESP_SLVERR;
                    end
                end
            end
            RD_RESP: begin
                if (rready) begin
                    next_rd_state = RD_IDLE;
                end
            end
            default: begin
                next_rd_state = RD_IDLE;
            end
        endcase
        next_arready = (next_rd_state == RD_IDLE);
    end

    // all state registered here; ce low holds everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 10; i++) begin
                res[i].value <= `VALUE_RST;
                res[i].upd <= 1'b0;
            end
            status <= `FLAGS_RST;
            mask <= `FLAGS_RST;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_idx <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rd_state <= RD_IDLE;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
            rd_was_result <= 1'b0;
            irq <= 1'b0;
        end else if (ce) begin
            res <= next_res;
            status <= next_status;
            mask <= next_mask;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_idx <= next_wr_idx;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rd_state <= next_rd_state;
            arready <= next_arready;
            rvalid <= (next_rd_state == RD_RESP);
            rdata <= next_rdata;
            rresp <= next_rresp;
            rd_was_result <= next_rd_was_result;
            irq <= next_irq;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // a load lands in its slot one cycle later
    a_low_value_load: assert property (
        ce && load.valid && load.slot == `SLOT_LOW_CH4
        |=> res[`SLOT_LOW_CH4].value == $past(load.value))
        else $error("low result not loaded");
    a_mid_value_load: assert property (
        ce && load.valid && load.slot == `SLOT_MID_CH4
        |=> res[`SLOT_MID_CH4].value == $past(load.value))
        else $error("mid result not loaded");
    a_high_value_load: assert property (
        ce && load.valid && load.slot == `SLOT_HIGH_CH4
        |=> res[`SLOT_HIGH_CH4].value == $past(load.value))
        else $error("high result not loaded");
    a_flag_on_load: assert property (
        ce && load_ok
        |=> res[$past(load.slot)].upd && status[$past(load.slot)])
        else $error("update flag not set by load");

    // read and write side effects; a load in the same cycle is allowed to win
    a_read_clears_flag: assert property (
        ce && ar_fire && rd_hit && !load.valid
        |=> !res[$past(rd_slot)].upd)
        else $error("read left update flag set");
    a_read_clears_all: assert property (
        ce && ar_fire && rd_hit && !load.valid
        |=> res[$past(rd_slot)] == '0)
        else $error("read left clearable bits");
    a_write_no_effect: assert property (
        ce && wr_go && !load.valid && !ar_fire
        |=> res == $past(res))
        else $error("write changed a result register");
    a_result_write_okay: assert property (
        ce && wr_go && is_result(wr_idx)
        |=> bvalid && bresp == `RESP_OKAY)
        else $error("result write not answered okay");
    a_hole_write_err: assert property (
        ce && wr_go && !is_result(wr_idx) && wr_idx != `ST_IRQ_STATUS_IDX
        && wr_idx != `ST_IRQ_MASK_IDX
        |=> bvalid && bresp == `RESP_SLVERR)
        else $error("unmapped write not refused");

    // address map, checked on the answer beat
    a_map_ch4_low: assert property (
        ce && ar_fire && rd_idx == `ST_CUR_LOW_CH4_IDX && rd_state == RD_IDLE
        |=> rvalid && rdata[`VAL_MSB:`VAL_LSB] == $past(res[`SLOT_LOW_CH4].value))
        else $error("channel 4 low read wrong");
    a_map_ch4_high: assert property (
        ce && ar_fire && rd_idx == `ST_CUR_HIGH_CH4_IDX
        |=> rvalid && rdata[`VAL_MSB:`VAL_LSB] == $past(res[`SLOT_HIGH_CH4].value))
        else $error("channel 4 high read wrong");
    a_map_ch5_low: assert property (
        ce && ar_fire && rd_idx == `ST_CUR_LOW_CH5_IDX && rd_state == RD_IDLE
        |=> rvalid && rdata[`UPD_BIT] == $past(res[`SLOT_LOW_CH5].upd))
        else $error("channel 5 low read wrong");
    a_map_ch6_high: assert property (
        ce && ar_fire && rd_idx == `ST_CUR_HIGH_CH6_IDX
        |=> rvalid && rdata[`VAL_MSB:`VAL_LSB] == $past(res[`SLOT_HIGH_CH6].value))
        else $error("channel 6 high read wrong");
    a_map_ch7_low: assert property (
        ce && ar_fire && rd_idx == `ST_CUR_LOW_CH7_IDX && rd_state == RD_IDLE
        |=> rvalid && rresp == `RESP_OKAY
        && rdata[`VAL_MSB:`VAL_LSB] == $past(res[`SLOT_LOW_CH7].value))
        else $error("channel 7 low read wrong");
    a_word_format: assert property (
        rvalid && rd_was_result
        |-> rdata[15:14] == 2'h0 && rdata[3:2] == 2'h0 && !(^rdata[15:0]))
        else $error("reserved bits or parity wrong");
    a_irq_follows: assert property (ce |=> irq == |(status & mask))
        else $error("interrupt out of step with status");

    // ce low must hold results, status and mask, rvalid and bvalid included
    a_freeze_hold: assert property (
        !ce |=> res == $past(res) && status == $past(status) && mask == $past(mask)
        && rvalid == $past(rvalid) && bvalid == $past(bvalid))
        else $error("state moved while clock enable low");

    c_load_then_read: cover property (ce && load_ok ##[1:20] ce && ar_fire && rd_hit);
    c_status_clear: cover property (ce && wr_go && wr_idx == `ST_IRQ_STATUS_IDX);
    c_irq_raised: cover property (!irq ##1 irq);
    c_load_during_read: cover property (ce && ar_fire && rd_hit && load_ok && load.slot == rd_slot);
    c_result_write: cover property (ce && wr_go && is_result(wr_idx));

endmodule

// file: sim/selftest_adc_result_regs_test.sv
// self-checking bench for the self-test result register bank
`timescale 1ns/1ps
`include "selftest_adc_map.svh"

module selftest_adc_result_regs_test import selftest_adc_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    result_load_type load = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, got;
    int fail_count = 0;
    int n_tests = 0;
    // boundary and alternating patterns, one per slot
    logic [9:0] vals [10] = '{10'h3ff, 10'h001, 10'h200, 10'h155, 10'h2aa,
                              10'h0f0, 10'h30f, 10'h0ff, 10'h100, 10'h3fe};

    selftest_adc_result_regs dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .load(load),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq)
    );

    // 40 mhz clock
    initial begin
        forever #12.5 aclk = ~aclk;
    end

    // byte address of result slot i
    function automatic logic [11:0] addr_of(input int i);
        return {2'b00, 8'h4d + 8'(i), 2'b00};
    endfunction

    // expected word: value, flag, zero pads, even parity in bit 0
    function automatic logic [31:0] exp_word(input logic [9:0] v, input logic u);
        logic [15:0] w;
        w = {2'b00, v, 2'b00, u, 1'b0};
        w[0] = ^w[15:1];
        return {16'h0000, w};
    endfunction

    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
        n_tests++;
        if (got_v !== exp_v) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask

    // bready stays high, so the response is taken at the first bvalid edge
    task automatic bus_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_pend;
        logic w_pend;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // no local limit: only the watchdog ends a hung wait
        while (aw_pend || w_pend) begin
            @(posedge aclk);
            if (aw_pend && awready === 1'b1) begin
                aw_pend = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_pend && wready === 1'b1) begin
                w_pend = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask

    // rready stays high; data is taken at the rvalid edge
    task automatic bus_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    // one-cycle conversion pulse from the sequencer side
    task automatic ld(input logic [3:0] s, input logic [9:0] v);
        load <= '{valid: 1'b1, slot: s, value: v};
        @(posedge aclk);
        load.valid <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog, far beyond the roughly 150 cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("MISMATCH t=%0t watchdog got=%h exp=%h", $time, 32'h0, 32'h1);
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 10; i++) begin
            bus_read(addr_of(i), got, resp);
            chk(got, 32'h0000_0000);
        end
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test reset values done");
        // every slot loaded, then read at its own index
        for (int i = 0; i < 10; i++) ld(4'(i), vals[i]);
        for (int i = 0; i < 10; i++) begin
            bus_read(addr_of(i), got, resp);
            chk(got, exp_word(vals[i], 1'b1));
            chk({30'h0, resp}, {30'h0, `RESP_OKAY});
        end
        for (int i = 0; i < 10; i++) begin
            bus_read(addr_of(i), got, resp);
            chk(got, 32'h0000_0000);
        end
        $display("test load and read-clear done");
        // a write payload must neither clear nor alter a result
        ld(4'h2, 10'h2aa);
        bus_write(addr_of(2), 32'hffff_ffff, resp);
        chk({30'h0, resp}, {30'h0, `RESP_OKAY});
        bus_read(addr_of(2), got, resp);
        chk(got, exp_word(10'h2aa, 1'b1));
        bus_read(addr_of(2), got, resp);
        chk(got, 32'h0000_0000);
        $display("test payload ignored done");
        // unmapped index
        bus_write(12'h100, 32'h0000_03ff, resp);
        chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
        bus_read(12'h100, got, resp);
        chk(got, 32'h0000_0000);
        chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
        $display("test unmapped done");
        // interrupt: all status bits pending, masked off, then bit 2 unmasked and all cleared
        bus_read(12'h1c0, got, resp);
        chk(got, 32'h0000_03ff);
        chk({31'h0, irq}, 32'h0000_0000);
        bus_write(12'h1c4, 32'h0000_0004, resp);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0001);
        bus_write(12'h1c0, 32'h0000_03fb, resp);
        bus_read(12'h1c0, got, resp);
        chk(got, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0000_0001);
        bus_write(12'h1c0, 32'h0000_0004, resp);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0000);
        bus_read(12'h1c4, got, resp);
        chk(got, 32'h0000_0004);
        ld(4'h2, 10'h155);
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0001);
        $display("test interrupt done");
        // byte strobes: only lane 1 reaches mask bits 9:8
        wstrb <= 4'h2;
        bus_write(12'h1c4, 32'h0000_03ff, resp);
        wstrb <= 4'hf;
        bus_read(12'h1c4, got, resp);
        chk(got, 32'h0000_0304);
        $display("test byte strobes done");
        // clock enable low: a conversion pulse in that window is lost
        ce <= 1'b0;
        ld(4'h0, 10'h123);
        ce <= 1'b1;
        bus_read(addr_of(0), got, resp);
        chk(got, 32'h0000_0000);
        bus_read(12'h1c0, got, resp);
        chk(got, 32'h0000_0004);
        $display("test clock enable done");
        // second reset in mid-run returns slots 0 and 2, the mask and irq to zero
        ld(4'h0, 10'h3ff);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        bus_read(addr_of(0), got, resp);
        chk(got, 32'h0000_0000);
        bus_read(addr_of(2), got, resp);
        chk(got, 32'h0000_0000);
        bus_read(12'h1c4, got, resp);
        chk(got, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
